// ---- hw/acl_cfg.svh ----
`ifndef ACL_CFG_SVH
`define ACL_CFG_SVH

// Address and field widths.
`define ACL_ADDR_W 32
`define ACL_FRAG_OFF_W 13
`define ACL_OPCODE_W 16

// Standard ARP and RARP operation codes.
`define ACL_OP_ARP_REQ 16'h0001
`define ACL_OP_ARP_REP 16'h0002
`define ACL_OP_RARP_REQ 16'h0003
`define ACL_OP_RARP_REP 16'h0004

// Reset values of the verdict flops and an all-ones mask.
`define ACL_VERDICT_RST 1'b0
`define ACL_MASK_ALL 32'hFFFF_FFFF
`define ACL_ZERO_BYTE 8'h00
`define ACL_ZERO_FRAG 13'h0000

`endif

// ---- hw/acl_pkg.sv ----
package acl_pkg;

    typedef enum logic [1:0] {
        ENTRY_ANY = 2'h0,
        ENTRY_ETYPE = 2'h1,
        ENTRY_ARP = 2'h2,
        ENTRY_IPV4 = 2'h3
    } entry_type_t;

    typedef enum logic [1:0] {
        KIND_OTHER = 2'h0,
        KIND_ARP = 2'h1,
        KIND_IPV4 = 2'h2
    } frame_kind_t;

    typedef enum logic [1:0] {
        TRI_ANY = 2'h0,
        TRI_NO = 2'h1,
        TRI_YES = 2'h2
    } tri_mode_t;

    typedef enum logic [1:0] {
        ADDR_ANY = 2'h0,
        ADDR_HOST = 2'h1,
        ADDR_NETWORK = 2'h2
    } addr_mode_t;

    typedef enum logic [1:0] {
        OPC_ANY = 2'h0,
        OPC_ARP = 2'h1,
        OPC_RARP = 2'h2,
        OPC_OTHER = 2'h3
    } opclass_t;

    typedef enum logic [1:0] {
        RR_ANY = 2'h0,
        RR_REQUEST = 2'h1,
        RR_REPLY = 2'h2
    } reqrep_t;

    typedef enum logic {
        ACT_PERMIT = 1'b0,
        ACT_DENY = 1'b1
    } action_t;

endpackage

// ---- hw/addr_filter.sv ----
`include "acl_cfg.svh"

module addr_filter (
    // Filter settings.
    input wire acl_pkg::addr_mode_t mode,
    input wire logic [`ACL_ADDR_W-1:0] cfg_addr,
    input wire logic [`ACL_ADDR_W-1:0] cfg_mask,
    // Address taken from the frame.
    input wire logic [`ACL_ADDR_W-1:0] frame_addr,
    // Filter verdict.
    output logic hit
);

    logic [`ACL_ADDR_W-1:0] eff_mask;

    // Host mode is a network compare under a full mask.
    always_comb begin
        case (mode)
            acl_pkg::ADDR_HOST: eff_mask = `ACL_MASK_ALL;
            acl_pkg::ADDR_NETWORK: eff_mask = cfg_mask;
            default: eff_mask = `ACL_MASK_ALL;
        endcase
    end

    // Only masked bits take part; an unused mode value never hits.
    always_comb begin
        case (mode)
            acl_pkg::ADDR_ANY: hit = 1'b1;
            acl_pkg::ADDR_HOST,
            acl_pkg::ADDR_NETWORK: hit = ((frame_addr ^ cfg_addr) & eff_mask) == '0;
            default: hit = 1'b0;
        endcase
    end

endmodule

// ---- hw/access_rule_entry.sv ----
// Summary of operation
// - Specific protocol mode matches only IPv4 frames with the configured protocol number.
// - TTL Zero refuses nonzero TTL, Non-zero needs nonzero TTL, Any ignores.
// - Fragmented means MF set or offset nonzero; No rejects, Yes requires.
// - Options No rejects flagged frames, Yes requires the flag, Any ignores.
// - Source address filter offers Any, Host equality, or Network masked compare.
// - Source Network mode compares only bits set in the source mask.
// - Destination address filter offers Any, Host equality, or Network masked compare.
// - Destination Network mode compares only bits set in the destination mask.
// - Opcode class selects Any, ARP, RARP, or neither known kind.
// - Request/reply selects Any, an ARP/RARP request, or an ARP/RARP reply.
// - Sender address filter offers Any, Host equality, or Network masked compare.
// - Sender Network mode compares only bits set in the sender mask.
// - On a full match Permit forwards the frame and Deny drops it.
// - IPv4 checks apply only to IPv4 entries; Ethernet-type entries skip IPv4.
`include "acl_cfg.svh"

module access_rule_entry (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Entry settings.
    input wire acl_pkg::entry_type_t entry_type,
    input wire acl_pkg::action_t action,
    input wire logic proto_specific,
    input wire logic [7:0] proto_value,
    input wire acl_pkg::tri_mode_t ttl_mode,
    input wire acl_pkg::tri_mode_t frag_mode,
    input wire acl_pkg::tri_mode_t opt_mode,
    input wire acl_pkg::addr_mode_t src_mode,
    input wire logic [`ACL_ADDR_W-1:0] src_addr,
    input wire logic [`ACL_ADDR_W-1:0] src_mask,
    input wire acl_pkg::addr_mode_t dst_mode,
    input wire logic [`ACL_ADDR_W-1:0] dst_addr,
    input wire logic [`ACL_ADDR_W-1:0] dst_mask,
    input wire acl_pkg::opclass_t opclass_mode,
    input wire acl_pkg::reqrep_t reqrep_mode,
    input wire acl_pkg::addr_mode_t sender_mode,
    input wire logic [`ACL_ADDR_W-1:0] sender_addr,
    input wire logic [`ACL_ADDR_W-1:0] sender_mask,
    // Header fields from the ingress parser.
    input wire logic frame_valid,
    input wire acl_pkg::frame_kind_t frame_kind,
    input wire logic [7:0] ip_proto,
    input wire logic [7:0] ip_ttl,
    input wire logic ip_more_frag,
    input wire logic [`ACL_FRAG_OFF_W-1:0] ip_frag_off,
    input wire logic ip_options,
    input wire logic [`ACL_ADDR_W-1:0] ip_src,
    input wire logic [`ACL_ADDR_W-1:0] ip_dst,
    input wire logic [`ACL_OPCODE_W-1:0] arp_opcode,
    input wire logic [`ACL_ADDR_W-1:0] arp_sender_ip,
    // Verdict, one cycle after the fields.
    output logic verdict_valid_r,
    output logic hit_r,
    output logic permit_r,
    output logic drop_r
);

    localparam int N_ADDR = 3;

    acl_pkg::addr_mode_t a_mode [N_ADDR];
    logic [`ACL_ADDR_W-1:0] a_cfg [N_ADDR];
    logic [`ACL_ADDR_W-1:0] a_msk [N_ADDR];
    logic [`ACL_ADDR_W-1:0] a_frm [N_ADDR];
    logic [N_ADDR-1:0] a_hit;

    logic source_ip_match;
    logic dest_ip_match;
    logic sender_hit;
    logic proto_ok, ttl_ok, frag_ok, opt_ok, fragmented;
    logic op_is_arp, op_is_rarp, op_is_req, op_is_rep;
    logic opc_ok, rr_ok;
    logic ipv4_ok, arp_ok, hit_nxt;

    assign a_mode[0] = src_mode;
    assign a_cfg[0] = src_addr;
    assign a_msk[0] = src_mask;
    assign a_frm[0] = ip_src;
    assign a_mode[1] = dst_mode;
    assign a_cfg[1] = dst_addr;
    assign a_msk[1] = dst_mask;
    assign a_frm[1] = ip_dst;
    assign a_mode[2] = sender_mode;
    assign a_cfg[2] = sender_addr;
    assign a_msk[2] = sender_mask;
    assign a_frm[2] = arp_sender_ip;

    // Source, destination and sender filters each get their own copy of the masked comparator.
    for (genvar i = 0; i < N_ADDR; i++) begin : g_addr
        addr_filter u_filter (
            .mode(a_mode[i]),
            .cfg_addr(a_cfg[i]),
            .cfg_mask(a_msk[i]),
            .frame_addr(a_frm[i]),
            .hit(a_hit[i])
        );
    end

    assign source_ip_match = a_hit[0];
    assign dest_ip_match = a_hit[1];
    assign sender_hit = a_hit[2];

    assign proto_ok = !proto_specific || (ip_proto == proto_value);

    always_comb begin
        case (ttl_mode)
            acl_pkg::TRI_NO: ttl_ok = (ip_ttl == `ACL_ZERO_BYTE);
            acl_pkg::TRI_YES: ttl_ok = (ip_ttl != `ACL_ZERO_BYTE);
            default: ttl_ok = 1'b1;
        endcase
    end

    assign fragmented = ip_more_frag || (ip_frag_off != `ACL_ZERO_FRAG);

    always_comb begin
        case (frag_mode)
            acl_pkg::TRI_NO: frag_ok = !fragmented;
            acl_pkg::TRI_YES: frag_ok = fragmented;
            default: frag_ok = 1'b1;
        endcase
    end

    always_comb begin
        case (opt_mode)
            acl_pkg::TRI_NO: opt_ok = !ip_options;
            acl_pkg::TRI_YES: opt_ok = ip_options;
            default: opt_ok = 1'b1;
        endcase
    end

    assign op_is_arp = (arp_opcode == `ACL_OP_ARP_REQ) || (arp_opcode == `ACL_OP_ARP_REP);
    assign op_is_rarp = (arp_opcode == `ACL_OP_RARP_REQ) || (arp_opcode == `ACL_OP_RARP_REP);
    assign op_is_req = (arp_opcode == `ACL_OP_ARP_REQ) || (arp_opcode == `ACL_OP_RARP_REQ);
    assign op_is_rep = (arp_opcode == `ACL_OP_ARP_REP) || (arp_opcode == `ACL_OP_RARP_REP);

    always_comb begin
        case (opclass_mode)
            acl_pkg::OPC_ARP: opc_ok = op_is_arp;
            acl_pkg::OPC_RARP: opc_ok = op_is_rarp;
            acl_pkg::OPC_OTHER: opc_ok = !op_is_arp && !op_is_rarp;
            default: opc_ok = 1'b1;
        endcase
    end

    always_comb begin
        case (reqrep_mode)
            acl_pkg::RR_REQUEST: rr_ok = op_is_req;
            acl_pkg::RR_REPLY: rr_ok = op_is_rep;
            default: rr_ok = 1'b1;
        endcase
    end

    // Every enabled criterion must hold together; Any criteria report true.
    assign ipv4_ok = proto_ok && ttl_ok && frag_ok && opt_ok && source_ip_match && dest_ip_match;
    assign arp_ok = opc_ok && rr_ok && sender_hit;

    // Field checks belong to the entry's own frame type, so an IPv4 or ARP
    // frame never reaches the Ethernet-type branch.
    always_comb begin
        case (entry_type)
            acl_pkg::ENTRY_ANY: hit_nxt = 1'b1;
            acl_pkg::ENTRY_ETYPE: hit_nxt = (frame_kind == acl_pkg::KIND_OTHER);
            acl_pkg::ENTRY_ARP: hit_nxt = (frame_kind == acl_pkg::KIND_ARP) && arp_ok;
            acl_pkg::ENTRY_IPV4: hit_nxt = (frame_kind == acl_pkg::KIND_IPV4) && ipv4_ok;
            default: hit_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            verdict_valid_r <= `ACL_VERDICT_RST;
        end else begin
            verdict_valid_r <= frame_valid;
        end
    end

    // Verdict lines move only with a frame or on reset, so they hold between frames.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hit_r <= `ACL_VERDICT_RST;
            permit_r <= `ACL_VERDICT_RST;
            drop_r <= `ACL_VERDICT_RST;
        end else if (frame_valid) begin
            hit_r <= hit_nxt;
            permit_r <= hit_nxt && (action == acl_pkg::ACT_PERMIT);
            drop_r <= hit_nxt && (action == acl_pkg::ACT_DENY);
        end
    end

    sequence s_ipv4_frame;
        frame_valid && frame_kind == acl_pkg::KIND_IPV4 && entry_type == acl_pkg::ENTRY_IPV4;
    endsequence

    sequence s_arp_frame;
        frame_valid && frame_kind == acl_pkg::KIND_ARP && entry_type == acl_pkg::ENTRY_ARP;
    endsequence

    a_proto_value: assert property (@(posedge clk_sys) disable iff (rst)
        s_ipv4_frame and (proto_specific && ip_proto != proto_value) ##1 verdict_valid_r
        |-> !hit_r)
        else $error("Protocol mismatch was matched.");

    a_ttl_zero: assert property (@(posedge clk_sys) disable iff (rst)
        s_ipv4_frame and (ttl_mode == acl_pkg::TRI_NO && ip_ttl != 8'h00) |=> !hit_r)
        else $error("Nonzero TTL matched a Zero entry.");

    a_ttl_nonzero: assert property (@(posedge clk_sys) disable iff (rst)
        s_ipv4_frame and (ttl_mode == acl_pkg::TRI_YES && ip_ttl == 8'h00) |=> !hit_r)
        else $error("Zero TTL matched a Non-zero entry.");

    a_frag_reject: assert property (@(posedge clk_sys) disable iff (rst)
        s_ipv4_frame and (frag_mode == acl_pkg::TRI_NO && (ip_more_frag || ip_frag_off != '0))
        |=> !hit_r && !permit_r && !drop_r)
        else $error("Fragment matched a No entry.");

    a_opt_require: assert property (@(posedge clk_sys) disable iff (rst)
        s_ipv4_frame and (opt_mode == acl_pkg::TRI_YES && !ip_options) |=> !hit_r)
        else $error("Frame without options matched a Yes entry.");

    a_src_network: assert property (@(posedge clk_sys) disable iff (rst)
        s_ipv4_frame and (src_mode == acl_pkg::ADDR_NETWORK
        && ((ip_src ^ src_addr) & src_mask) != '0)
        |=> !hit_r)
        else $error("Source outside the network matched.");

    a_dst_host: assert property (@(posedge clk_sys) disable iff (rst)
        s_ipv4_frame and (dst_mode == acl_pkg::ADDR_HOST && ip_dst != dst_addr) |=> !hit_r)
        else $error("Destination host mismatch matched.");

    a_opclass_rarp: assert property (@(posedge clk_sys) disable iff (rst)
        s_arp_frame and (opclass_mode == acl_pkg::OPC_RARP && arp_opcode == `ACL_OP_ARP_REQ)
        |=> !hit_r)
        else $error("ARP opcode matched a RARP entry.");

    a_sender_net: assert property (@(posedge clk_sys) disable iff (rst)
        s_arp_frame and (opclass_mode == acl_pkg::OPC_ANY && reqrep_mode == acl_pkg::RR_ANY
        && sender_mode == acl_pkg::ADDR_NETWORK
        && ((arp_sender_ip ^ sender_addr) & sender_mask) == '0)
        |=> hit_r)
        else $error("Sender inside the network was missed.");

    a_etype_ipv4: assert property (@(posedge clk_sys) disable iff (rst)
        frame_valid && entry_type == acl_pkg::ENTRY_ETYPE && frame_kind != acl_pkg::KIND_OTHER
        |=> !hit_r)
        else $error("Ethernet-type entry matched an IPv4 or ARP frame.");

    a_action_split: assert property (@(posedge clk_sys) disable iff (rst)
        verdict_valid_r |-> (permit_r == (hit_r && $past(action) == acl_pkg::ACT_PERMIT))
        && (drop_r == (hit_r && $past(action) == acl_pkg::ACT_DENY)))
        else $error("Action does not follow the match.");

    a_all_any: assert property (@(posedge clk_sys) disable iff (rst)
        s_ipv4_frame and (!proto_specific && ttl_mode == acl_pkg::TRI_ANY
        && frag_mode == acl_pkg::TRI_ANY && opt_mode == acl_pkg::TRI_ANY
        && src_mode == acl_pkg::ADDR_ANY && dst_mode == acl_pkg::ADDR_ANY) |=> hit_r)
        else $error("All-Any IPv4 entry failed to match.");

endmodule

// ---- verification/frame_source.sv ----
module frame_source (
    // Clock.
    input wire logic clk_sys,
    // Header fields towards the entry.
    output logic frame_valid,
    output acl_pkg::frame_kind_t frame_kind,
    output logic [7:0] ip_proto,
    output logic [7:0] ip_ttl,
    output logic ip_more_frag,
    output logic [12:0] ip_frag_off,
    output logic ip_options,
    output logic [31:0] ip_src,
    output logic [31:0] ip_dst,
    output logic [15:0] arp_opcode,
    output logic [31:0] arp_sender_ip
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        frame_valid = 1'b0;
        {ip_proto, ip_ttl, ip_more_frag, ip_frag_off, ip_options} = '0;
        {ip_src, ip_dst, arp_opcode, arp_sender_ip} = '0;
        frame_kind = acl_pkg::KIND_OTHER;
    end

    // Fields are only valid in the frame cycle, so afterwards they flip to catch stale use.
    task automatic send(input acl_pkg::frame_kind_t k, input logic [7:0] p, input logic [7:0] t,
                        input logic m, input logic [12:0] f, input logic o,
                        input logic [31:0] s, input logic [31:0] d, input logic [15:0] c,
                        input logic [31:0] n);
        @(posedge clk_sys);
        frame_valid <= 1'b1;
        frame_kind <= k;
        {ip_proto, ip_ttl, ip_more_frag, ip_frag_off, ip_options} <= {p, t, m, f, o};
        {ip_src, ip_dst, arp_opcode, arp_sender_ip} <= {s, d, c, n};
        @(posedge clk_sys);
        frame_valid <= 1'b0;
        frame_kind <= acl_pkg::frame_kind_t'(~k);
        {ip_proto, ip_ttl, ip_more_frag, ip_frag_off, ip_options} <= ~{p, t, m, f, o};
        {ip_src, ip_dst, arp_opcode, arp_sender_ip} <= ~{s, d, c, n};
    endtask
endmodule

// ---- verification/access_rule_entry_bench.sv ----
module access_rule_entry_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    acl_pkg::entry_type_t entry_type = acl_pkg::ENTRY_IPV4;
    acl_pkg::action_t action = acl_pkg::ACT_PERMIT;
    logic proto_specific = 1'b0;
    logic [7:0] proto_value = 8'h00;
    acl_pkg::tri_mode_t ttl_mode = acl_pkg::TRI_ANY;
    acl_pkg::tri_mode_t frag_mode = acl_pkg::TRI_ANY;
    acl_pkg::tri_mode_t opt_mode = acl_pkg::TRI_ANY;
    acl_pkg::addr_mode_t src_mode = acl_pkg::ADDR_ANY;
    acl_pkg::addr_mode_t dst_mode = acl_pkg::ADDR_ANY;
    acl_pkg::addr_mode_t sender_mode = acl_pkg::ADDR_ANY;
    logic [31:0] src_addr = 32'h0000_0000;
    logic [31:0] src_mask = 32'h0000_0000;
    logic [31:0] dst_addr = 32'h0000_0000;
    logic [31:0] dst_mask = 32'h0000_0000;
    logic [31:0] sender_addr = 32'h0000_0000;
    logic [31:0] sender_mask = 32'h0000_0000;
    acl_pkg::opclass_t opclass_mode = acl_pkg::OPC_ANY;
    acl_pkg::reqrep_t reqrep_mode = acl_pkg::RR_ANY;
    logic frame_valid, ip_more_frag, ip_options;
    acl_pkg::frame_kind_t frame_kind, k;
    logic [7:0] ip_proto, ip_ttl, pr, tl;
    logic [12:0] ip_frag_off, fo;
    logic [31:0] ip_src, ip_dst, arp_sender_ip, sa, da, sp;
    logic [15:0] arp_opcode, oc;
    logic verdict_valid_r, hit_r, permit_r, drop_r, mf, op;
    localparam logic [31:0] A = 32'hC0A8_0101;
    int n_errors = 0;
    int compares = 0;

    frame_source u_frame_source (.clk_sys, .frame_valid, .frame_kind, .ip_proto, .ip_ttl,
        .ip_more_frag, .ip_frag_off, .ip_options, .ip_src, .ip_dst, .arp_opcode, .arp_sender_ip);
    access_rule_entry u_access_rule_entry (.clk_sys, .rst, .entry_type, .action,
        .proto_specific, .proto_value, .ttl_mode, .frag_mode, .opt_mode, .src_mode, .src_addr,
        .src_mask, .dst_mode, .dst_addr, .dst_mask, .opclass_mode, .reqrep_mode, .sender_mode,
        .sender_addr, .sender_mask, .frame_valid, .frame_kind, .ip_proto, .ip_ttl,
        .ip_more_frag, .ip_frag_off, .ip_options, .ip_src, .ip_dst, .arp_opcode,
        .arp_sender_ip, .verdict_valid_r, .hit_r, .permit_r, .drop_r);

    always #5 clk_sys = ~clk_sys;

    task automatic cmp_bit(input string name, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", name, e, g);
        end
    endtask

    task automatic complete_run;
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic go(input logic e);
        u_frame_source.send(k, pr, tl, mf, fo, op, sa, da, oc, sp);
        #1;
        cmp_bit("verdict_valid_r", 1'b1, verdict_valid_r);
        cmp_bit("hit_r", e, hit_r);
        cmp_bit("permit_r", e && action == acl_pkg::ACT_PERMIT, permit_r);
        cmp_bit("drop_r", e && action == acl_pkg::ACT_DENY, drop_r);
    endtask

    task automatic dflt;
        @(posedge clk_sys);
        entry_type <= acl_pkg::ENTRY_IPV4;
        action <= acl_pkg::ACT_PERMIT;
        proto_specific <= 1'b0;
        ttl_mode <= acl_pkg::TRI_ANY;
        frag_mode <= acl_pkg::TRI_ANY;
        opt_mode <= acl_pkg::TRI_ANY;
        src_mode <= acl_pkg::ADDR_ANY;
        dst_mode <= acl_pkg::ADDR_ANY;
        sender_mode <= acl_pkg::ADDR_ANY;
        opclass_mode <= acl_pkg::OPC_ANY;
        reqrep_mode <= acl_pkg::RR_ANY;
        {src_addr, dst_addr, sender_addr} <= {A, A, A};
        {src_mask, dst_mask, sender_mask} <= {3{32'hFFFF_FF00}};
        k = acl_pkg::KIND_IPV4;
        {pr, tl, mf, fo, op} = {8'h06, 8'h40, 1'b0, 13'h0000, 1'b0};
        {sa, da, sp, oc} = {A, A, A, 16'h0001};
    endtask

    task automatic amode(input int w, input acl_pkg::addr_mode_t m);
        @(posedge clk_sys);
        if (w == 0) begin
            src_mode <= m;
        end else if (w == 1) begin
            dst_mode <= m;
        end else begin
            sender_mode <= m;
            entry_type <= acl_pkg::ENTRY_ARP;
            k = acl_pkg::KIND_ARP;
        end
    endtask

    task automatic fld(input int w, input logic [31:0] v);
        sa = (w == 0) ? v : A;
        da = (w == 1) ? v : A;
        sp = (w == 2) ? v : A;
    endtask

    function automatic logic arp_ok(input acl_pkg::opclass_t c, input acl_pkg::reqrep_t r,
                                    input logic [15:0] o);
        logic a, b;
        a = (o == 16'h0001 || o == 16'h0002);
        b = (o == 16'h0003 || o == 16'h0004);
        if ((c == acl_pkg::OPC_ARP && !a) || (c == acl_pkg::OPC_RARP && !b)) return 1'b0;
        if (c == acl_pkg::OPC_OTHER && (a || b)) return 1'b0;
        if (r == acl_pkg::RR_REQUEST) return o == 16'h0001 || o == 16'h0003;
        if (r == acl_pkg::RR_REPLY) return o == 16'h0002 || o == 16'h0004;
        return 1'b1;
    endfunction

    // The whole sequence needs well under a thousand cycles; this bound leaves ample slack.
    initial begin
        #50000;
        n_errors++;
        complete_run;
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        cmp_bit("hit_r", 1'b0, hit_r);
        dflt;
        go(1'b1);
        k = acl_pkg::KIND_OTHER;
        go(1'b0);
        @(posedge clk_sys);
        entry_type <= acl_pkg::ENTRY_ETYPE;
        go(1'b1);
        k = acl_pkg::KIND_IPV4;
        go(1'b0);
        @(posedge clk_sys);
        entry_type <= acl_pkg::ENTRY_ANY;
        go(1'b1);
        k = acl_pkg::KIND_ARP;
        go(1'b1);
        @(posedge clk_sys);
        entry_type <= acl_pkg::ENTRY_ARP;
        k = acl_pkg::KIND_IPV4;
        go(1'b0);
        dflt;
        @(posedge clk_sys);
        {proto_specific, proto_value} <= {1'b1, 8'hFF};
        pr = 8'hFF;
        go(1'b1);
        @(posedge clk_sys);
        #1;
        cmp_bit("verdict_valid_r", 1'b0, verdict_valid_r);
        cmp_bit("hit_r", 1'b1, hit_r);
        pr = 8'hFE;
        go(1'b0);
        @(posedge clk_sys);
        proto_value <= 8'h00;
        pr = 8'h00;
        go(1'b1);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        cmp_bit("hit_r", 1'b0, hit_r);
        cmp_bit("permit_r", 1'b0, permit_r);
        cmp_bit("drop_r", 1'b0, drop_r);
        dflt;
        @(posedge clk_sys);
        ttl_mode <= acl_pkg::TRI_NO;
        frag_mode <= acl_pkg::TRI_NO;
        opt_mode <= acl_pkg::TRI_NO;
        tl = 8'h00;
        go(1'b1);
        {tl, mf} = {8'h01, 1'b0};
        go(1'b0);
        {tl, mf} = {8'h00, 1'b1};
        go(1'b0);
        {mf, fo} = {1'b0, 13'h1000};
        go(1'b0);
        {fo, op} = {13'h0000, 1'b1};
        go(1'b0);
        @(posedge clk_sys);
        ttl_mode <= acl_pkg::TRI_YES;
        frag_mode <= acl_pkg::TRI_YES;
        opt_mode <= acl_pkg::TRI_YES;
        {tl, fo} = {8'h80, 13'h0001};
        go(1'b1);
        tl = 8'h00;
        go(1'b0);
        {tl, fo} = {8'h80, 13'h0000};
        go(1'b0);
        {fo, op} = {13'h0001, 1'b0};
        go(1'b0);
        for (int w = 0; w < 3; w++) begin
            dflt;
            amode(w, acl_pkg::ADDR_HOST);
            go(1'b1);
            fld(w, A ^ 32'h0000_0001);
            go(1'b0);
            fld(w, A ^ 32'h8000_0000);
            go(1'b0);
            amode(w, acl_pkg::ADDR_NETWORK);
            fld(w, A ^ 32'h0000_00FF);
            go(1'b1);
            fld(w, A ^ 32'h0000_0100);
            go(1'b0);
        end
        dflt;
        amode(2, acl_pkg::ADDR_ANY);
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 3; r++) begin
                @(posedge clk_sys);
                opclass_mode <= acl_pkg::opclass_t'(c);
                reqrep_mode <= acl_pkg::reqrep_t'(r);
                action <= acl_pkg::action_t'(r[0]);
                for (int o = 0; o < 6; o++) begin
                    oc = 16'(o);
                    go(arp_ok(acl_pkg::opclass_t'(c), acl_pkg::reqrep_t'(r), oc));
                end
            end
        end
        complete_run;
    end
endmodule
